//--- shared/kmw_pkg.sv
// Purpose: Constants for the keyboard/mouse interrupt and wake glue.
// Assumes: AXI4-Lite byte addresses, 32-bit data, 8-bit registers in low bits.
// Notes: Register offsets are byte addresses.
package kmw_pkg;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] CORE_RESET_CFG_ADDR = 12'h02C;
   localparam logic [ADDR_W-1:0] LATCH_ISO_CTRL_ADDR = 12'h0F0;
   localparam logic [ADDR_W-1:0] WAKE_STATUS_ADDR = 12'h100;
   localparam logic [ADDR_W-1:0] WAKE_ENABLE_ADDR = 12'h104;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h108;
   localparam logic [ADDR_W-1:0] LINE_STATE_ADDR = 12'h10C;
   // Core reset register field
   localparam int CORE_RESET_BIT = 6;
   // Latch/isolation register fields
   localparam int KBD_LATCH_BIT = 3;
   localparam int MOUSE_LATCH_BIT = 4;
   localparam int KBD_ISO_BIT = 5;
   localparam int MOUSE_ISO_BIT = 6;
   // Wake status / enable fields
   localparam int EV_KBD_IRQ = 0;
   localparam int EV_MOUSE_IRQ = 1;
   localparam int EV_KBD_DATA = 2;
   localparam int EV_MOUSE_DATA = 3;
   localparam int EV_GLOBAL = 7;
   localparam int NUM_EV = 4;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

//--- design/kmw_sync.sv
// Purpose: Two-flop synchroniser with an edge pulse on the synced level.
// Assumes: Input is asynchronous to clock_in.
// Notes: First flop feeds only the second one.
`timescale 1ns/1ps
`default_nettype none
module kmw_sync
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Asynchronous level in
   input wire logic async_in,
   // Synchronised level and falling edge
   output logic level_out,
   output logic fall_out
);
   logic stage1;
   logic stage2;
   logic stage3;
   // Idle level of open-drain lines is high
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
         stage3 <= 1'b1;
      end
      else
      begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end
   assign level_out = stage2;
   assign fall_out = stage3 & ~stage2;
endmodule
`default_nettype wire

//--- design/kmw_top.sv
// Purpose: Keyboard/mouse interrupt conditioning, wake events, line
//    isolation and core reset for an embedded keyboard controller core.
// Assumes: Single 10 MHz clock; AXI4-Lite slave for registers.
// Notes: Active data-line edge is the falling edge (start bit).
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module kmw_top
   import kmw_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [kmw_pkg::ADDR_W-1:0] s_axi_awaddr,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [kmw_pkg::ADDR_W-1:0] s_axi_araddr,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Controller core interrupts (same clock)
   input wire logic core_kbd_irq_in,
   input wire logic core_mouse_irq_in,
   // Conditioned interrupts to the host
   output logic kbd_irq_out,
   output logic mouse_irq_out,
   // Keyboard/mouse pins (asynchronous)
   input wire logic kbd_clock_line_in,
   input wire logic kbd_data_line_in,
   input wire logic mouse_clock_line_in,
   input wire logic mouse_data_line_in,
   // Lines towards the controller core
   output logic core_kbd_clock_out,
   output logic core_kbd_data_out,
   output logic core_mouse_clock_out,
   output logic core_mouse_data_out,
   // Power state and core reset
   input wire logic main_power_good_in,
   output logic core_reset_out,
   // Wake and interrupt outputs
   output logic wake_event_out,
   output logic irq_out
);
   logic [7:0] core_reset_cfg;
   logic [7:0] latch_iso_ctrl;
   logic [7:0] wake_enable;
   logic [7:0] irq_mask;
   logic [NUM_EV-1:0] wake_status;
   logic kbd_irq_latched;
   logic mouse_irq_latched;
   logic kbd_irq_prev;
   logic mouse_irq_prev;
   logic have_aw;
   logic have_w;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [31:0] read_data;
   logic [1:0] read_resp;
   logic power_sync1;
   logic power_good;
   logic kbd_clock_sync;
   logic kbd_data_sync;
   logic mouse_clock_sync;
   logic mouse_data_sync;
   logic kbd_data_fall;
   logic mouse_data_fall;

   // Pin synchronisers
   kmw_sync u_kbd_clock
   (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .async_in(kbd_clock_line_in),
      .level_out(kbd_clock_sync),
      .fall_out()
   );
   kmw_sync u_kbd_data
   (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .async_in(kbd_data_line_in),
      .level_out(kbd_data_sync),
      .fall_out(kbd_data_fall)
   );
   kmw_sync u_mouse_clock
   (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .async_in(mouse_clock_line_in),
      .level_out(mouse_clock_sync),
      .fall_out()
   );
   kmw_sync u_mouse_data
   (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .async_in(mouse_data_line_in),
      .level_out(mouse_data_sync),
      .fall_out(mouse_data_fall)
   );

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         power_sync1 <= 1'b0;
         power_good <= 1'b0;
      end
      else
      begin
         power_sync1 <= main_power_good_in;
         power_good <= power_sync1;
      end
   end

   // Isolation: blocked lines are held at the idle high level
   wire kbd_iso = latch_iso_ctrl[KBD_ISO_BIT];
   wire mouse_iso = latch_iso_ctrl[MOUSE_ISO_BIT];
   assign core_kbd_clock_out = kbd_clock_sync | kbd_iso;
   assign core_kbd_data_out = kbd_data_sync | kbd_iso;
   assign core_mouse_clock_out = mouse_clock_sync | mouse_iso;
   assign core_mouse_data_out = mouse_data_sync | mouse_iso;

   // Interrupt latches catch a rising core interrupt and hold it until the
   // core drops the line while the ANDed mode is in use
   wire kbd_irq_rise = core_kbd_irq_in & ~kbd_irq_prev;
   wire mouse_irq_rise = core_mouse_irq_in & ~mouse_irq_prev;
   wire kbd_latch_sel = latch_iso_ctrl[KBD_LATCH_BIT];
   wire mouse_latch_sel = latch_iso_ctrl[MOUSE_LATCH_BIT];
   wire next_kbd_irq_latched = kbd_irq_rise |
      (kbd_irq_latched & (core_kbd_irq_in | kbd_latch_sel));
   wire next_mouse_irq_latched = mouse_irq_rise |
      (mouse_irq_latched & (core_mouse_irq_in | mouse_latch_sel));
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         kbd_irq_latched <= 1'b0;
         mouse_irq_latched <= 1'b0;
         kbd_irq_prev <= 1'b0;
         mouse_irq_prev <= 1'b0;
      end
      else
      begin
         // A latch in latched-alone mode clears once the core line is low
         // and the mode returns to ANDed; that keeps reads deterministic
         kbd_irq_latched <= next_kbd_irq_latched;
         mouse_irq_latched <= next_mouse_irq_latched;
         kbd_irq_prev <= core_kbd_irq_in;
         mouse_irq_prev <= core_mouse_irq_in;
      end
   end
   assign kbd_irq_out = kbd_latch_sel ? kbd_irq_latched :
      (core_kbd_irq_in & kbd_irq_latched);
   assign mouse_irq_out = mouse_latch_sel ? mouse_irq_latched :
      (core_mouse_irq_in & mouse_irq_latched);

   // Wake events; irq sources only count on main power
   logic [NUM_EV-1:0] ev_set;
   assign ev_set[EV_KBD_IRQ] = kbd_irq_rise & power_good;
   assign ev_set[EV_MOUSE_IRQ] = mouse_irq_rise & power_good;
   assign ev_set[EV_KBD_DATA] = kbd_data_fall;
   assign ev_set[EV_MOUSE_DATA] = mouse_data_fall;
   assign wake_event_out = wake_enable[EV_GLOBAL] &
      (|(wake_status & wake_enable[NUM_EV-1:0]));
   assign irq_out = |(wake_status & irq_mask[NUM_EV-1:0]);
   assign core_reset_out = core_reset_cfg[CORE_RESET_BIT];

   // AXI4-Lite write side
   assign s_axi_awready = ~have_aw & ~s_axi_bvalid;
   assign s_axi_wready = ~have_w & ~s_axi_bvalid;
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire wr_go = have_aw & have_w;
   wire wr_lane0 = wr_go & w_strb[0];
   wire wr_core = wr_lane0 && aw_addr == CORE_RESET_CFG_ADDR;
   wire wr_ctrl = wr_lane0 && aw_addr == LATCH_ISO_CTRL_ADDR;
   wire wr_stat = wr_lane0 && aw_addr == WAKE_STATUS_ADDR;
   wire wr_en = wr_lane0 && aw_addr == WAKE_ENABLE_ADDR;
   wire wr_mask = wr_lane0 && aw_addr == IRQ_MASK_ADDR;
   wire wr_hit = aw_addr == CORE_RESET_CFG_ADDR ||
      aw_addr == LATCH_ISO_CTRL_ADDR || aw_addr == WAKE_STATUS_ADDR ||
      aw_addr == WAKE_ENABLE_ADDR || aw_addr == IRQ_MASK_ADDR;
   // Set wins over a simultaneous write-one clear
   wire [NUM_EV-1:0] stat_clr = wr_stat ? w_data[NUM_EV-1:0] : '0;
   wire [NUM_EV-1:0] next_wake_status = (wake_status & ~stat_clr) | ev_set;

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         have_aw <= 1'b0;
         have_w <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         if (aw_fire)
         begin
            have_aw <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_fire)
         begin
            have_w <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Registers; reset bit holds until software writes it back to zero
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         core_reset_cfg <= REG_RESET;
         latch_iso_ctrl <= REG_RESET;
         wake_enable <= REG_RESET;
         irq_mask <= REG_RESET;
         wake_status <= '0;
      end
      else
      begin
         if (wr_core)
            core_reset_cfg <= w_data[7:0];
         if (wr_ctrl)
            latch_iso_ctrl <= w_data[7:0];
         if (wr_en)
            wake_enable <= w_data[7:0];
         if (wr_mask)
            irq_mask <= w_data[7:0];
         wake_status <= next_wake_status;
      end
   end

   // AXI4-Lite read side
   assign s_axi_arready = ~s_axi_rvalid;
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire [7:0] line_state = {4'h0, mouse_clock_sync, mouse_data_sync,
      kbd_clock_sync, kbd_data_sync};
   always_comb
   begin
      read_data = 32'h0000_0000;
      read_resp = RESP_OKAY;
      unique case (s_axi_araddr)
         CORE_RESET_CFG_ADDR: read_data[7:0] = core_reset_cfg;
         LATCH_ISO_CTRL_ADDR: read_data[7:0] = latch_iso_ctrl;
         WAKE_STATUS_ADDR: read_data[NUM_EV-1:0] = wake_status;
         WAKE_ENABLE_ADDR: read_data[7:0] = wake_enable;
         IRQ_MASK_ADDR: read_data[7:0] = irq_mask;
         LINE_STATE_ADDR: read_data[7:0] = line_state;
         default: read_resp = RESP_DECERR;
      endcase
   end
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (ar_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= read_data;
         s_axi_rresp <= read_resp;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- verif/kmw_monitor.sv
// Purpose: Port assertions for the keyboard/mouse wake glue.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to kmw_top from the testbench.
`timescale 1ns/1ps
`default_nettype none
module kmw_monitor
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Bus and core reset
   input wire logic s_axi_bvalid,
   input wire logic core_reset_out,
   // Interrupts
   input wire logic core_kbd_irq_in,
   input wire logic core_mouse_irq_in,
   input wire logic kbd_irq_out,
   input wire logic mouse_irq_out,
   input wire logic irq_out,
   // Lines
   input wire logic kbd_clock_line_in,
   input wire logic mouse_data_line_in,
   input wire logic core_kbd_clock_out,
   input wire logic core_mouse_data_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   a_kbd_rise_cause: assert property ($rose(kbd_irq_out) |->
      $past(core_kbd_irq_in)) else $error("kbd irq rose uncaused");
   a_mouse_rise_cause: assert property ($rose(mouse_irq_out) |->
      $past(core_mouse_irq_in)) else $error("mouse irq rose uncaused");
   a_kbd_irq_follow: assert property ($rose(core_kbd_irq_in) ##1
      core_kbd_irq_in |-> kbd_irq_out) else $error("kbd irq late");
   a_mouse_irq_follow: assert property ($rose(core_mouse_irq_in) ##1
      core_mouse_irq_in |-> mouse_irq_out) else $error("mouse irq late");
   // A low towards the core needs a low pin two flops earlier
   a_kbd_clk_gate: assert property (!core_kbd_clock_out |->
      !$past(kbd_clock_line_in, 2)) else $error("kbd clock leaked");
   a_mouse_dat_gate: assert property (!core_mouse_data_out |->
      !$past(mouse_data_line_in, 2)) else $error("mouse data leaked");
   a_core_rst_write: assert property ($changed(core_reset_out) |->
      $rose(s_axi_bvalid)) else $error("core reset moved alone");
   a_latch_reset_clear: assert property ($rose(rst_n_in) |->
      !kbd_irq_out && !mouse_irq_out) else $error("stale latch");
   cover property ($rose(kbd_irq_out));
   cover property ($rose(irq_out));
   cover property ($rose(core_reset_out));
endmodule
`default_nettype wire

//--- verif/kmw_core_model.sv
// Purpose: Behavioural controller core raising raw interrupts.
// Assumes: Same clock as the glue.
// Notes: Requests come from the testbench.
`timescale 1ns/1ps
`default_nettype none
module kmw_core_model
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Core reset and requests
   input wire logic core_reset_in,
   input wire logic kbd_req_in,
   input wire logic mouse_req_in,
   // Raw interrupts
   output logic core_kbd_irq_out,
   output logic core_mouse_irq_out
);
   // A core held in reset keeps its interrupts quiet
   always_ff @(posedge clock_in)
   begin
      core_kbd_irq_out <= rst_n_in & ~core_reset_in & kbd_req_in;
      core_mouse_irq_out <= rst_n_in & ~core_reset_in & mouse_req_in;
   end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Purpose: Self-checking bench for the keyboard/mouse wake glue.
// Assumes: 10 MHz clock, AXI4-Lite master tasks.
// Notes: Pins idle high; order is kbd clk, kbd dat, mouse clk, dat.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import kmw_pkg::*;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = 12'h000;
   logic [ADDR_W-1:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, core_kbd_irq_in, core_mouse_irq_in;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   logic [31:0] s_axi_rdata, rd_data;
   logic kbd_irq_out, mouse_irq_out, core_reset_out, wake_event_out;
   logic irq_out, core_kbd_clock_out, core_kbd_data_out;
   logic core_mouse_clock_out, core_mouse_data_out;
   logic kbd_clock_line_in = 1'b1;
   logic kbd_data_line_in = 1'b1;
   logic mouse_clock_line_in = 1'b1;
   logic mouse_data_line_in = 1'b1;
   logic main_power_good_in = 1'b1;
   logic [1:0] req = 2'h0;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   wire logic [31:0] irqs = {30'h0, mouse_irq_out, kbd_irq_out};
   kmw_top u_dut (.*);
   kmw_core_model u_core (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .core_reset_in(core_reset_out), .kbd_req_in(req[0]),
      .mouse_req_in(req[1]), .core_kbd_irq_out(core_kbd_irq_in),
      .core_mouse_irq_out(core_mouse_irq_in));
   always #50 clock_in = ~clock_in;
   // Whole run needs about 350 cycles
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      if (fail_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clock_in);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      wr_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input string what, input logic [11:0] a,
      input logic [7:0] e);
      @(posedge clock_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clock_in);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(what, {24'h000000, e}, rd_data);
   endtask
   task automatic irq_pulse(input logic [1:0] r);
      @(posedge clock_in);
      req <= r;
      cyc(4);
      req <= 2'h0;
      cyc(4);
   endtask
   // Six cycles cover the two sync flops and the edge detector
   task automatic set_pins(input logic [3:0] p);
      @(posedge clock_in);
      {kbd_clock_line_in, kbd_data_line_in, mouse_clock_line_in,
         mouse_data_line_in} <= p;
      cyc(6);
   endtask
   task automatic t_regs;
      rd("core reset reg", CORE_RESET_CFG_ADDR, 8'h00);
      rd("latch iso reg", LATCH_ISO_CTRL_ADDR, 8'h00);
      rd("line state", LINE_STATE_ADDR, 8'h0F);
      wr(LATCH_ISO_CTRL_ADDR, 8'h78);
      chk("write resp", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
      rd("latch iso back", LATCH_ISO_CTRL_ADDR, 8'h78);
      wr(LATCH_ISO_CTRL_ADDR, 8'h00);
      wr(12'h200, 8'h00);
      chk("unmapped wr", {30'h0, RESP_DECERR}, {30'h0, wr_resp});
      rd("unmapped data", 12'h200, 8'h00);
      chk("unmapped resp", {30'h0, RESP_DECERR}, {30'h0, rd_resp});
   endtask
   task automatic t_latch;
      logic [1:0] r;
      for (int i = 0; i < 2; i++)
      begin
         r = 2'h1 << i;
         @(posedge clock_in);
         req <= r;
         cyc(4);
         chk("irq raised", {30'h0, r}, irqs);
         req <= 2'h0;
         cyc(4);
         chk("irq anded", 32'h0, irqs);
         wr(LATCH_ISO_CTRL_ADDR, (i == 1) ? 8'h10 : 8'h08);
         irq_pulse(r);
         chk("irq latched", {30'h0, r}, irqs);
         wr(LATCH_ISO_CTRL_ADDR, 8'h00);
         cyc(2);
         chk("latch freed", 32'h0, irqs);
      end
   endtask
   task automatic t_wake;
      wr(WAKE_STATUS_ADDR, 8'h0F);
      wr(WAKE_ENABLE_ADDR, 8'h8F);
      wr(IRQ_MASK_ADDR, 8'h0F);
      irq_pulse(2'h1);
      rd("kbd irq event", WAKE_STATUS_ADDR, 8'h01);
      chk("wake out", 32'h1, {31'h0, wake_event_out});
      irq_pulse(2'h2);
      rd("mouse irq event", WAKE_STATUS_ADDR, 8'h03);
      chk("irq out", 32'h1, {31'h0, irq_out});
      wr(IRQ_MASK_ADDR, 8'h00);
      chk("irq masked", 32'h0, {31'h0, irq_out});
      wr(WAKE_ENABLE_ADDR, 8'h0F);
      chk("global off", 32'h0, {31'h0, wake_event_out});
      wr(WAKE_STATUS_ADDR, 8'h0F);
      main_power_good_in <= 1'b0;
      irq_pulse(2'h3);
      set_pins(4'hB);
      set_pins(4'hF);
      rd("standby kbd", WAKE_STATUS_ADDR, 8'h04);
      set_pins(4'hE);
      set_pins(4'hF);
      rd("standby mouse", WAKE_STATUS_ADDR, 8'h0C);
      main_power_good_in <= 1'b1;
      wr(WAKE_ENABLE_ADDR, 8'h84);
      chk("kbd data wake", 32'h1, {31'h0, wake_event_out});
      wr(WAKE_ENABLE_ADDR, 8'h80);
      chk("none enabled", 32'h0, {31'h0, wake_event_out});
      wr(IRQ_MASK_ADDR, 8'h08);
      chk("irq unmasked", 32'h1, {31'h0, irq_out});
      wr(WAKE_STATUS_ADDR, 8'h0F);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
   endtask
   task automatic t_iso;
      logic [7:0] iso [4] = '{8'h60, 8'h20, 8'h40, 8'h00};
      logic [3:0] e [4] = '{4'hF, 4'hC, 4'h3, 4'h0};
      for (int i = 0; i < 4; i++)
      begin
         wr(LATCH_ISO_CTRL_ADDR, iso[i]);
         set_pins(4'h0);
         chk("core lines", {28'h0, e[i]}, {28'h0, core_kbd_clock_out,
            core_kbd_data_out, core_mouse_clock_out,
            core_mouse_data_out});
         set_pins(4'hF);
         rd("wake feed", WAKE_STATUS_ADDR, 8'h0C);
         wr(WAKE_STATUS_ADDR, 8'h0F);
      end
   endtask
   task automatic t_rst;
      // Isolated lines through a main power loss call for a core reset
      wr(LATCH_ISO_CTRL_ADDR, 8'h60);
      main_power_good_in <= 1'b0;
      cyc(8);
      main_power_good_in <= 1'b1;
      cyc(4);
      wr(CORE_RESET_CFG_ADDR, 8'h40);
      cyc(10);
      chk("core in reset", 32'h1, {31'h0, core_reset_out});
      rd("reset bit kept", CORE_RESET_CFG_ADDR, 8'h40);
      wr(CORE_RESET_CFG_ADDR, 8'h00);
      chk("core released", 32'h0, {31'h0, core_reset_out});
      wr(LATCH_ISO_CTRL_ADDR, 8'h08);
      irq_pulse(2'h1);
      chk("latch held", 32'h1, irqs);
      rst_n_in <= 1'b0;
      cyc(4);
      rst_n_in <= 1'b1;
      cyc(1);
      chk("latch reset", 32'h0, irqs);
      // Latched-alone mode exposes a latch that survived reset
      wr(LATCH_ISO_CTRL_ADDR, 8'h08);
      chk("latch reset sel", 32'h0, irqs);
   endtask
   initial
   begin
      cyc(4);
      rst_n_in <= 1'b1;
      t_regs();
      t_latch();
      t_wake();
      t_iso();
      t_rst();
      tally_and_finish();
   end
endmodule
bind kmw_top kmw_monitor u_mon (.*);
`default_nettype wire
